// ===== core/sfcu_unit.sv
/*
 * Shifter, condition-flag and branch-condition unit behind an AHB-Lite slave.
 * Assumes one AHB-Lite master, whole-word transfers, and hclk at 20 MHz.
 */
module sfcu_unit
    import sfcu_pkg::*;
#(
    parameter int unsigned DEC_W = 8
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    output logic             fatal_fault_exception
);

    if (DEC_W < 6 || DEC_W > 32) begin : g_bad_dec
        $error("sfcu_unit: DEC_W must lie between 6 and 32");
    end

    typedef struct packed {
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] result;
        logic [31:0] pc;
        logic [31:0] rdata;
        logic [3:0]  flags;
        logic        taken;
        logic        fault;
        logic        ns_ok;
        logic        fault_pulse;
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
    } sfcu_state_s;

    sfcu_state_s st_reg;
    sfcu_state_s st_next;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic and shift datapath.

    logic [WORD_W-1:0] sh_res;
    logic              sh_carry;
    logic              sh_upd;
    logic [WORD_W:0]   add_sum;
    logic [WORD_W:0]   sub_dif;
    logic              add_ovf;
    logic              sub_ovf;
    logic [31:0]       pc_operand;
    logic              cmd_exec;
    logic              addr_take;
    logic [7:0]        dec_addr;

    sfcu_barrel u_barrel (
        .src       (st_reg.opa),
        .len       (st_reg.opb[LEN_W-1:0]),
        .kind      (sfcu_shift_e'(hwdata[CMD_OP_LSB +: 2])),
        .res       (sh_res),
        .carry     (sh_carry),
        .carry_upd (sh_upd)
    );

    assign add_sum = {1'b0, st_reg.opa} + {1'b0, st_reg.opb};
    assign sub_dif = {1'b0, st_reg.opa} + {1'b0, ~st_reg.opb} + 33'h0_0000_0001;
    assign add_ovf = (st_reg.opa[31] == st_reg.opb[31]) && (add_sum[31] != st_reg.opa[31]);
    assign sub_ovf = (st_reg.opa[31] != st_reg.opb[31]) && (sub_dif[31] != st_reg.opa[31]);
    assign pc_operand = st_reg.pc + PC_AHEAD;
    assign cmd_exec   = st_reg.wr && (st_reg.addr == OFF_COMMAND);
    assign addr_take  = hsel && hready && htrans[1];
    assign dec_addr   = 8'(haddr[DEC_W-1:0]);

    function automatic logic cond_met(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        n  = f[FLAG_N];
        z  = f[FLAG_Z];
        cy = f[FLAG_C];
        v  = f[FLAG_V];
        unique case (sfcu_cond_e'(c))
            ZERO_SET_COND:           cond_met = z;
            ZERO_CLEAR_COND:         cond_met = !z;
            CARRY_SET_COND:          cond_met = cy;
            CARRY_CLEAR_COND:        cond_met = !cy;
            NEGATIVE_COND:           cond_met = n;
            NONNEGATIVE_COND:        cond_met = !n;
            OVERFLOW_SET_COND:       cond_met = v;
            OVERFLOW_CLEAR_COND:     cond_met = !v;
            UNSIGNED_ABOVE_COND:     cond_met = cy && !z;
            UNSIGNED_NOT_ABOVE_COND: cond_met = !cy || z;
            SIGNED_AT_LEAST_COND:    cond_met = (n == v);
            SIGNED_BELOW_COND:       cond_met = (n != v);
            SIGNED_ABOVE_COND:       cond_met = !z && (n == v);
            SIGNED_AT_MOST_COND:     cond_met = z || (n != v);
            NO_CONDITION_DEFAULT:    cond_met = 1'b1;
            default:                 cond_met = 1'b1;
        endcase
    endfunction

    function automatic logic [3:0] nzcv(input logic [31:0] r, input logic c, input logic v);
        logic [3:0] f;
        f         = '0;
        f[FLAG_N] = r[31];
        f[FLAG_Z] = (r == '0);
        f[FLAG_C] = c;
        f[FLAG_V] = v;
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and command execution.

    always_comb begin
        logic [3:0]  op;
        logic        setf;
        logic        fault_set;
        logic [31:0] rmux;
        op        = hwdata[CMD_OP_LSB +: 4];
        setf      = hwdata[CMD_SETF_BIT];
        fault_set = 1'b0;
        rmux      = RST_WORD;
        st_next   = st_reg;
        st_next.fault_pulse = 1'b0;

        unique case (st_reg.addr)
            OFF_OPERAND_A:  rmux = st_reg.opa;
            OFF_OPERAND_B:  rmux = st_reg.opb;
            OFF_RESULT:     rmux = st_reg.result;
            OFF_FLAGS:      rmux = {28'h000_0000, st_reg.flags};
            OFF_STATUS:     rmux = {29'h0000_0000, st_reg.ns_ok, st_reg.fault, st_reg.taken};
            OFF_PROG_CNT:   rmux = st_reg.pc;
            OFF_PC_OPERAND: rmux = pc_operand;
            default:        rmux = RST_WORD;
        endcase

        // Reads take one wait state so a write just before is visible.
        if (st_reg.rd) begin
            st_next.rdata = rmux;
            st_next.rd    = 1'b0;
        end

        if (st_reg.wr) begin
            unique case (st_reg.addr)
                OFF_OPERAND_A: st_next.opa   = hwdata;
                OFF_OPERAND_B: st_next.opb   = hwdata;
                OFF_FLAGS:     st_next.flags = hwdata[3:0];
                OFF_PROG_CNT:  st_next.pc    = hwdata;
                default:       st_next.opa   = st_reg.opa;
            endcase
        end

        if (cmd_exec) begin
            unique case (op)
                OP_ARITH_SHIFT_RIGHT, OP_LOGICAL_SHIFT_RIGHT,
                OP_LOGICAL_SHIFT_LEFT, OP_ROTATE_RIGHT: begin
                    st_next.result = sh_res;
                    if (setf) begin
                        st_next.flags = nzcv(sh_res, sh_upd ? sh_carry : st_reg.flags[FLAG_C],
                                             st_reg.flags[FLAG_V]);
                    end
                end
                OP_ADD: begin
                    st_next.result = add_sum[31:0];
                    if (setf) begin
                        st_next.flags = nzcv(add_sum[31:0], add_sum[32], add_ovf);
                    end
                end
                OP_SUB: begin
                    st_next.result = sub_dif[31:0];
                    if (setf) begin
                        st_next.flags = nzcv(sub_dif[31:0], sub_dif[32], sub_ovf);
                    end
                end
                OP_COMPARE_SUBTRACT: st_next.flags = nzcv(sub_dif[31:0], sub_dif[32], sub_ovf);
                OP_COMPARE_NEGATED_ADD: st_next.flags = nzcv(add_sum[31:0], add_sum[32], add_ovf);
                OP_COND_BRANCH: begin
                    st_next.taken = cond_met(hwdata[CMD_COND_LSB +: 4], st_reg.flags);
                    if (st_next.taken) begin
                        st_next.pc = pc_operand + st_reg.opb;
                    end
                end
                OP_BRANCH_EXCHANGE: begin
                    // target bit 0 must be set
                    if (st_reg.opa[0]) begin
                        st_next.pc = {st_reg.opa[31:1], 1'b0};
                    end else begin
                        fault_set = 1'b1;
                    end
                end
                OP_BRANCH_WITH_LINK: begin
                    st_next.result = {pc_operand[31:1], 1'b1};
                    st_next.pc     = pc_operand + st_reg.opb;
                end
                OP_BRANCH_TO_NONSECURE: begin
                    st_next.ns_ok = !st_reg.opa[0];
                    st_next.pc    = {st_reg.opa[31:1], 1'b0};
                end
                OP_ALIGN_CHECK: begin
                    unique case (st_reg.opb[1:0])
                        SIZE_HALF: fault_set = st_reg.opa[0];
                        SIZE_WORD: fault_set = (st_reg.opa[1:0] != 2'b00);
                        default:   fault_set = 1'b0;
                    endcase
                end
                default: st_next.taken = st_reg.taken;
            endcase
        end

        // A new fault wins over a simultaneous write-one-to-clear.
        st_next.fault = fault_set
                      | (st_reg.fault & ~(st_reg.wr && st_reg.addr == OFF_STATUS && hwdata[STAT_FAULT]));
        st_next.fault_pulse = fault_set;

        if (hready) begin
            st_next.wr = addr_take && hwrite;
            st_next.rd = addr_take && !hwrite;
            if (addr_take) begin
                st_next.addr = dec_addr;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg       <= '0;
            st_reg.flags <= RST_FLAGS;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout             = !st_reg.rd;
    assign hresp                 = 1'b0;
    assign hrdata                = st_reg.rdata;
    assign fatal_fault_exception = st_reg.fault_pulse;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_cmd(logic [3:0] opc);
        cmd_exec && hwdata[3:0] == opc && hwdata[CMD_SETF_BIT];
    endsequence

    sequence s_len(int lo, int hi);
        st_reg.opb[7:0] >= lo && st_reg.opb[7:0] <= hi;
    endsequence

    a_asr_long_sign: assert property (s_cmd(OP_ARITH_SHIFT_RIGHT) and s_len(32, 255) |=>
        st_reg.result == {32{$past(st_reg.opa[31])}} && st_reg.flags[FLAG_C] == $past(st_reg.opa[31]))
        else $error("long arithmetic shift did not fill with sign");

    a_lsr_long_zero: assert property (s_cmd(OP_LOGICAL_SHIFT_RIGHT) and s_len(33, 255) |=>
        st_reg.result == '0 && !st_reg.flags[FLAG_C])
        else $error("logical shift by 33 or more not cleared");

    a_lsl_short_val: assert property (s_cmd(OP_LOGICAL_SHIFT_LEFT) and s_len(1, 31) |=>
        st_reg.result == ($past(st_reg.opa) << $past(st_reg.opb[4:0])))
        else $error("left shift result wrong");

    a_shift_zero_keep: assert property (s_cmd(OP_ROTATE_RIGHT) and s_len(0, 0) |=>
        st_reg.result == $past(st_reg.opa) && $stable(st_reg.flags[FLAG_C]))
        else $error("zero length shift changed operand or carry");

    a_ror_32_keep: assert property (s_cmd(OP_ROTATE_RIGHT) and s_len(32, 32) |=>
        st_reg.result == $past(st_reg.opa) && st_reg.flags[FLAG_C] == $past(st_reg.opa[31]))
        else $error("rotate by 32 wrong");

    a_cmp_discard: assert property (cmd_exec && hwdata[3:0] == OP_COMPARE_SUBTRACT |=>
        $stable(st_reg.result) && st_reg.flags[FLAG_C] == ($past(st_reg.opa) >= $past(st_reg.opb)))
        else $error("compare altered result or carry wrong");

    a_noflag_hold: assert property (cmd_exec && !hwdata[CMD_SETF_BIT] && hwdata[3:1] != 3'b011
        |=> $stable(st_reg.flags))
        else $error("flags changed without flag update");

    a_branch_gate: assert property (cmd_exec && hwdata[3:0] == OP_COND_BRANCH
        && hwdata[11:8] == ZERO_SET_COND && !st_reg.flags[FLAG_Z] |=> $stable(st_reg.pc) && !st_reg.taken)
        else $error("branch taken with condition false");

    a_link_bit: assert property (cmd_exec && hwdata[3:0] == OP_BRANCH_WITH_LINK |=>
        st_reg.result[0] && st_reg.result[31:1] == $past(pc_operand[31:1]))
        else $error("link value wrong");

    sequence s_fault_once;
        fatal_fault_exception ##1 !fatal_fault_exception;
    endsequence

    a_align_fault: assert property (cmd_exec && hwdata[3:0] == OP_ALIGN_CHECK
        && st_reg.opb[1:0] == SIZE_WORD && st_reg.opa[1:0] != 2'b00 |=> s_fault_once and st_reg.fault)
        else $error("misaligned word access did not fault");

    a_read_wait: assert property (addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not one cycle");

endmodule // sfcu_unit

// ===== core/sfcu_pkg.sv
/*
 * Shared constants and types of the shifter, flags and condition unit.
 * Assumes a single AHB-Lite master and whole-word register accesses.
 */
package sfcu_pkg;

    localparam int unsigned WORD_W = 32;
    localparam int unsigned LEN_W  = 8;

    // Register byte offsets within the decoded window.
    localparam logic [7:0] OFF_OPERAND_A  = 8'h00;
    localparam logic [7:0] OFF_OPERAND_B  = 8'h04;
    localparam logic [7:0] OFF_COMMAND    = 8'h08;
    localparam logic [7:0] OFF_RESULT     = 8'h0C;
    localparam logic [7:0] OFF_FLAGS      = 8'h10;
    localparam logic [7:0] OFF_STATUS     = 8'h14;
    localparam logic [7:0] OFF_PROG_CNT   = 8'h18;
    localparam logic [7:0] OFF_PC_OPERAND = 8'h1C;

    // Command word fields.
    localparam int unsigned CMD_OP_LSB   = 0;
    localparam int unsigned CMD_SETF_BIT = 4;
    localparam int unsigned CMD_COND_LSB = 8;

    // Flag bit positions in the program_status_flags word.
    localparam int unsigned FLAG_V = 0;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_N = 3;

    // Status bit positions; the fault bit is write-one-to-clear.
    localparam int unsigned STAT_TAKEN = 0;
    localparam int unsigned STAT_FAULT = 1;
    localparam int unsigned STAT_NS_OK = 2;

    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [3:0]  RST_FLAGS    = 4'h0;
    localparam logic [31:0] PC_AHEAD     = 32'h0000_0004;
    localparam logic [LEN_W-1:0] LEN_32  = 8'h20;

    // Access sizes for the alignment check.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [1:0] {
        SH_ASR = 2'b00,
        SH_LSR = 2'b01,
        SH_LSL = 2'b10,
        SH_ROR = 2'b11
    } sfcu_shift_e;

    typedef enum logic [3:0] {
        OP_ARITH_SHIFT_RIGHT   = 4'b0000,
        OP_LOGICAL_SHIFT_RIGHT = 4'b0001,
        OP_LOGICAL_SHIFT_LEFT  = 4'b0010,
        OP_ROTATE_RIGHT        = 4'b0011,
        OP_ADD                 = 4'b0100,
        OP_SUB                 = 4'b0101,
        OP_COMPARE_SUBTRACT    = 4'b0110,
        OP_COMPARE_NEGATED_ADD = 4'b0111,
        OP_COND_BRANCH         = 4'b1000,
        OP_BRANCH_EXCHANGE     = 4'b1001,
        OP_BRANCH_WITH_LINK    = 4'b1010,
        OP_BRANCH_TO_NONSECURE = 4'b1011,
        OP_ALIGN_CHECK         = 4'b1100
    } sfcu_op_e;

    typedef enum logic [3:0] {
        ZERO_SET_COND           = 4'b0000,
        ZERO_CLEAR_COND         = 4'b0001,
        CARRY_SET_COND          = 4'b0010,
        CARRY_CLEAR_COND        = 4'b0011,
        NEGATIVE_COND           = 4'b0100,
        NONNEGATIVE_COND        = 4'b0101,
        OVERFLOW_SET_COND       = 4'b0110,
        OVERFLOW_CLEAR_COND     = 4'b0111,
        UNSIGNED_ABOVE_COND     = 4'b1000,
        UNSIGNED_NOT_ABOVE_COND = 4'b1001,
        SIGNED_AT_LEAST_COND    = 4'b1010,
        SIGNED_BELOW_COND       = 4'b1011,
        SIGNED_ABOVE_COND       = 4'b1100,
        SIGNED_AT_MOST_COND     = 4'b1101,
        NO_CONDITION_DEFAULT    = 4'b1110
    } sfcu_cond_e;

endpackage : sfcu_pkg

// ===== core/sfcu_barrel.sv
/*
 * Combinational barrel shifter with carry-out for the four shift kinds.
 * Assumes the caller applies carry only when carry_upd is high.
 */
module sfcu_barrel
    import sfcu_pkg::*;
(
    input  wire logic [WORD_W-1:0] src,
    input  wire logic [LEN_W-1:0]  len,
    input  wire sfcu_shift_e       kind,
    output logic      [WORD_W-1:0] res,
    output logic                   carry,
    output logic                   carry_upd
);

    always_comb begin
        logic [2*WORD_W-1:0] dbl;
        logic [4:0]          m;
        dbl       = {src, src};
        m         = len[4:0];
        res       = src;
        carry     = 1'b0;
        carry_upd = (len != '0);
        if (len != '0) begin
            unique case (kind)
                SH_ASR: begin
                    if (len >= LEN_32) begin
                        res   = {WORD_W{src[WORD_W-1]}};
                        carry = src[WORD_W-1];
                    end else begin
                        res   = $signed(src) >>> m;
                        carry = src[m - 5'd1];
                    end
                end
                SH_LSR: begin
                    if (len >= LEN_32) begin
                        res   = '0;
                        carry = (len == LEN_32) ? src[WORD_W-1] : 1'b0;
                    end else begin
                        res   = src >> m;
                        carry = src[m - 5'd1];
                    end
                end
                SH_LSL: begin
                    if (len >= LEN_32) begin
                        res   = '0;
                        carry = (len == LEN_32) ? src[0] : 1'b0;
                    end else begin
                        res   = src << m;
                        carry = src[5'(6'd32 - {1'b0, m})];
                    end
                end
                SH_ROR: begin
                    if (m == 5'd0) begin
                        res   = src;
                        carry = src[WORD_W-1];
                    end else begin
                        res   = dbl[m +: WORD_W];
                        carry = src[m - 5'd1];
                    end
                end
            endcase
        end
    end

endmodule // sfcu_barrel

// ===== tb/tb_shifter_flags_condition_unit.sv
/*
 * Self-checking bench for the shifter, flags and condition unit.
 * Assumes the unit is the only AHB-Lite slave, so its hreadyout is the bus hready.
 */
module tb_shifter_flags_condition_unit
    import sfcu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          fails, checked, pulses;

    sfcu_unit #(.DEC_W(8)) sfcu_unit_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .fatal_fault_exception(fault));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // The pulse is one cycle wide, so every edge is looked at.
    always @(posedge hclk) begin
        if (fault === 1'b1) pulses++;
        if (hresetn === 1'b1 && hresp !== 1'b0) begin
            fails++;
            $display("Error hresp expected 0 seen %b", hresp);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single transfer; the iff samples hready before the edge updates it.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge hclk iff hreadyout === 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    task automatic run(input logic [31:0] a, input logic [31:0] b, input logic [3:0] f, input logic [31:0] cmd);
        bus(1'b1, OFF_OPERAND_A, a);
        bus(1'b1, OFF_OPERAND_B, b);
        bus(1'b1, OFF_FLAGS, {28'h0, f});
        bus(1'b1, OFF_COMMAND, cmd);
    endtask

    function automatic void ref_shift(input int k, input logic [31:0] a, input int n, input logic ci,
                                      output logic [31:0] r, output logic c);
        int m;
        m = n % 32;
        r = a;
        c = ci;
        if (n == 0) return;
        if (k == 0) begin
            r = (n >= 32) ? {32{a[31]}} : 32'($signed(a) >>> n);
            c = a[(n >= 32) ? 31 : n - 1];
        end else if (k == 1) begin
            r = (n >= 32) ? 32'h0000_0000 : a >> n;
            c = (n > 32) ? 1'b0 : a[n - 1];
        end else if (k == 2) begin
            r = (n >= 32) ? 32'h0000_0000 : a << n;
            c = (n > 32) ? 1'b0 : a[32 - n];
        end else begin
            r = (m == 0) ? a : (a >> m) | (a << (32 - m));
            c = (m == 0) ? a[31] : a[m - 1];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0000_0000);
            chk("reset value", (i == 7) ? PC_AHEAD : RST_WORD, rd);
        end
        bus(1'b1, OFF_OPERAND_A, 32'hA5A5_5A5A);
        bus(1'b1, 8'h24, 32'hFFFF_FFFF);
        bus(1'b1, OFF_RESULT, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h24, RST_WORD);
        rchk("result read only", OFF_RESULT, RST_WORD);
        rchk("operand a", OFF_OPERAND_A, 32'hA5A5_5A5A);
        $display("register test done");
    endtask

    task automatic t_shift();
        logic [31:0] r;
        logic [3:0]  f;
        logic        c;
        int          lens[7] = '{0, 1, 4, 31, 32, 33, 40};
        for (int k = 0; k < 4; k++) begin
            foreach (lens[i]) begin
                f = 4'(i * 3 + k);
                ref_shift(k, 32'h8000_00F1, lens[i], f[1], r, c);
                run(32'h8000_00F1, 32'(lens[i]), f, 32'(16 + k));
                rchk("shift result", OFF_RESULT, r);
                rchk("shift flags", OFF_FLAGS, {28'h0, r[31], r == 32'h0, c, f[0]});
            end
        end
        $display("shift test done");
    endtask

    task automatic t_arith();
        logic [31:0] a[5] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0000_0005, 32'h0000_0003, 32'h8000_0000};
        logic [31:0] b[5] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0005, 32'h0000_0005, 32'h0000_0001};
        logic [32:0] s;
        logic [31:0] bb;
        logic        v;
        logic        sb;
        for (int op = 4; op < 8; op++) begin
            // Subtract and compare_subtract both add the inverted operand plus one.
            sb = (op == 5) || (op == 6);
            foreach (a[i]) begin
                bb = sb ? ~b[i] : b[i];
                s = {1'b0, a[i]} + {1'b0, bb} + 33'(sb);
                v = (a[i][31] == bb[31]) && (s[31] != a[i][31]);
                run(32'h0000_1234, 32'h0000_0000, 4'hF, 32'h0000_0004);
                rchk("flags kept", OFF_FLAGS, 32'h0000_000F);
                run(a[i], b[i], 4'h0, 32'(16 + op));
                rchk("arith result", OFF_RESULT, (op < 6) ? s[31:0] : 32'h0000_1234);
                rchk("arith flags", OFF_FLAGS, {28'h0, s[31], s[31:0] == 32'h0, s[32], v});
            end
        end
        $display("arithmetic test done");
    endtask

    task automatic t_cond();
        logic n, z, c, v, t;
        for (int cc = 0; cc < 15; cc++) begin
            for (int f = 0; f < 16; f++) begin
                {n, z, c, v} = f[3:0];
                case (cc >> 1)
                    0: t = z;
                    1: t = c;
                    2: t = n;
                    3: t = v;
                    4: t = c & ~z;
                    5: t = (n == v);
                    6: t = ~z & (n == v);
                    default: t = 1'b1;
                endcase
                // Odd codes are the inverse of the even code below them.
                t = t ^ cc[0];
                bus(1'b1, OFF_PROG_CNT, 32'h0000_0100);
                run(32'h0000_0000, 32'h0000_0020, f[3:0], {20'h0, cc[3:0], 8'h08});
                bus(1'b0, OFF_STATUS, 32'h0000_0000);
                chk("taken", 32'(t), 32'(rd[STAT_TAKEN]));
                rchk("branch pc", OFF_PROG_CNT, t ? 32'h0000_0124 : 32'h0000_0100);
            end
        end
        $display("condition test done");
    endtask

    task automatic t_branch();
        int p0;
        p0 = pulses;
        bus(1'b1, OFF_PROG_CNT, 32'h0000_0200);
        rchk("pc operand", OFF_PC_OPERAND, 32'h0000_0204);
        run(32'h0000_0301, 32'h0000_0000, 4'h0, 32'h0000_0009);
        rchk("exchange pc", OFF_PROG_CNT, 32'h0000_0300);
        run(32'h0000_0400, 32'h0000_0000, 4'h0, 32'h0000_0009);
        rchk("exchange kept", OFF_PROG_CNT, 32'h0000_0300);
        chk("exchange pulses", 32'(p0 + 1), 32'(pulses));
        run(32'h0000_0000, 32'h0000_0010, 4'h0, 32'h0000_000A);
        rchk("link value", OFF_RESULT, 32'h0000_0305);
        rchk("link pc", OFF_PROG_CNT, 32'h0000_0314);
        for (int i = 0; i < 2; i++) begin
            run(32'h0000_0500 | i, 32'h0000_0000, 4'h0, 32'h0000_000B);
            bus(1'b0, OFF_STATUS, 32'h0000_0000);
            chk("nonsecure ok", 32'(1 - i), 32'(rd[STAT_NS_OK]));
            chk("fault sticky", 32'h0000_0001, 32'(rd[STAT_FAULT]));
        end
        bus(1'b1, OFF_STATUS, 32'h0000_0002);
        bus(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("fault cleared", 32'h0000_0000, 32'(rd[STAT_FAULT]));
        $display("branch test done");
    endtask

    task automatic t_align();
        logic e;
        int   p0;
        for (int s = 0; s < 4; s++) begin
            for (int lo = 0; lo < 4; lo++) begin
                e = (s == 1 && lo[0]) || (s == 2 && lo[1:0] != 2'h0);
                p0 = pulses;
                run(32'h0000_1000 | lo, 32'(s), 4'h0, 32'h0000_000C);
                bus(1'b1, OFF_STATUS, 32'h0000_0002);
                chk("align fault", 32'(e), 32'(pulses - p0));
            end
        end
        $display("alignment test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // About 7200 bus cycles are expected; the limit leaves ample margin.
    initial begin
        #(80000 * 50);
        fails++;
        test_done();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        fails = 0;
        checked = 0;
        pulses = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_shift();
        t_arith();
        t_cond();
        t_branch();
        t_align();
        test_done();
    end
endmodule // tb_shifter_flags_condition_unit
